// >>> hdl/ams_pkg.sv
// Shared constants and types for the antenna match sequencer.
// Assumes a single 40 MHz clock and a 32-bit register bus.
package ams_pkg;
   localparam int COIL_N        = 9;
   localparam int CAP_N         = 10;
   localparam int ANT_N         = 4;
   localparam int DET_W         = 8;
   // Binary weighted banks: step of the smallest coil and capacitor.
   localparam int COIL_STEP_PH  = 15;
   localparam int CAP_STEP_PF   = 3;

   localparam int CLK_HZ        = 40_000_000;
   localparam int TICK_CYCLES   = CLK_HZ / 1000;
   localparam int PULSE_MS      = 3;
   localparam int SETTLE_MS     = 10;
   localparam int PULSE_TICKS   = PULSE_MS;
   localparam int SETTLE_TICKS  = SETTLE_MS;

   // Reflected power times this ratio below forward power means SWR under 1.3.
   localparam int MATCH_RATIO   = 59;

   localparam logic [4:0] REG_CTRL   = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_COIL   = 5'h08;
   localparam logic [4:0] REG_CAP    = 5'h0c;
   localparam logic [4:0] REG_SAVED  = 5'h10;

   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_ANT_LSB   = 1;
   localparam int CTRL_HV_BIT    = 3;
   localparam logic [1:0] CTRL_ANT_RST = 2'h0;
   localparam logic       CTRL_HV_RST  = 1'b0;
   localparam logic [ANT_N-1:0] ANT_RST = 4'h1;

   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_DONE_BIT  = 1;
   localparam int ST_MATCH_BIT = 2;
   localparam int ST_EXH_BIT   = 3;
   localparam int ST_WAIT_BIT  = 4;

   localparam int ENTRY_COIL_LSB = 0;
   localparam int ENTRY_CAP_LSB  = COIL_N;
   localparam int ENTRY_SIDE_BIT = COIL_N + CAP_N;
   localparam int ENTRY_W        = COIL_N + CAP_N + 1;

   localparam logic [COIL_N-1:0] COIL_MAX = '1;
   localparam logic [CAP_N-1:0]  CAP_MAX  = '1;

   typedef enum logic {SIDE_L, SIDE_RL} ams_side_t;
   typedef enum logic [2:0] {
      S_IDLE, S_ARM, S_SETUP, S_SETTLE, S_PULSE, S_EVAL, S_REPORT
   } ams_state_t;
endpackage

// >>> hdl/ams_step_if.sv
// Carrier between the sequencer and its step evaluator.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface ams_step_if import ams_pkg::*;;
   logic              r_above;
   logic              g_above;
   logic              reactance_sign_bit;
   logic [DET_W-1:0]  fwd;
   logic [DET_W-1:0]  refl;
   logic [COIL_N-1:0] coil;
   logic [CAP_N-1:0]  cap;
   ams_side_t         side;
   logic              matched;
   logic              exhausted;
   logic [COIL_N-1:0] next_coil;
   logic [CAP_N-1:0]  next_cap;
   ams_side_t         next_side;
   modport seq  (output r_above, g_above, reactance_sign_bit, fwd, refl, coil, cap, side,
                 input matched, exhausted, next_coil, next_cap, next_side);
   modport eval (input r_above, g_above, reactance_sign_bit, fwd, refl, coil, cap, side,
                 output matched, exhausted, next_coil, next_cap, next_side);
endinterface
`default_nettype wire

// >>> hdl/ams_step_eval.sv
// Step evaluator: judges one set of sampled readings and picks the next relays.
// Assumes the sequencer holds its inputs stable while it reads the result.
`timescale 1ns/1ps
`default_nettype none
module ams_step_eval import ams_pkg::*; (
   ams_step_if.eval s
);
   always_comb begin
      // Reflected-to-forward ratio test stands in for the SWR circle.
      s.matched   = ({8'h00, s.refl} * 16'(MATCH_RATIO)) < {8'h00, s.fwd};
      s.next_coil = s.coil;
      s.next_cap  = s.cap;
      s.next_side = s.side;
      s.exhausted = 1'b0;
      // A fresh network picks its side from the resistance comparator.
      if (s.coil == '0 && s.cap == '0) begin
         s.next_side = s.r_above ? SIDE_RL : SIDE_L;
      end
      if (s.reactance_sign_bit) begin
         if (s.coil != '0) begin
            s.next_coil = s.coil - 9'h001;
         end else if (s.cap != CAP_MAX) begin
            s.next_cap = s.cap + 10'h001;
         end else begin
            s.exhausted = 1'b1;
         end
      end else if (s.g_above && s.cap != '0) begin
         s.next_cap = s.cap - 10'h001;
      end else if (s.coil != COIL_MAX) begin
         s.next_coil = s.coil + 9'h001;
      end else begin
         s.exhausted = 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/ams_store.sv
// Small store for the matched relay combination, one entry per antenna.
// Stands in for the nonvolatile memory; read data come out of a register.
`timescale 1ns/1ps
`default_nettype none
module ams_store import ams_pkg::*; (
   input  wire logic               clk_i,
   input  wire logic               we_i,
   input  wire logic [1:0]         waddr_i,
   input  wire logic [ENTRY_W-1:0] wdata_i,
   input  wire logic [1:0]         raddr_i,
   output var  logic [ENTRY_W-1:0] rdata_o
);
   logic [ENTRY_W-1:0] mem [ANT_N];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      rdata_o <= mem[raddr_i];
   end
endmodule
`default_nettype wire

// >>> hdl/ams_seq.sv
// Antenna match tuning sequencer with an Avalon-MM register slave.
// Assumes synchronous sensor inputs and a continuous carrier while tuning.
`timescale 1ns/1ps
`default_nettype none
module ams_seq import ams_pkg::*; #(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic [4:0]        avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   output var  logic [31:0]       avs_readdata_o,
   output var  logic              avs_waitrequest_o,
   input  wire logic              r_above_i,
   input  wire logic              g_above_i,
   input  wire logic              reactance_sign_bit_i,
   input  wire logic [DET_W-1:0]  fwd_level_i,
   input  wire logic [DET_W-1:0]  refl_level_i,
   input  wire logic              tx_active_i,
   output var  logic [COIL_N-1:0] series_coil_relays_o,
   output var  logic [CAP_N-1:0]  shunt_cap_relays_o,
   output var  logic              input_side_cap_relay_o,
   output var  logic              output_side_cap_relay_o,
   output var  logic [ANT_N-1:0]  antenna_select_relays_o,
   output var  logic              high_voltage_enable_o,
   output var  logic              input_bypass_relay_o,
   output var  logic              sensor_route_relay_o,
   output var  logic              rf_block_gate_o,
   output var  logic              tune_done_o,
   output var  logic              tune_matched_o
);
   ams_state_t         state;
   ams_side_t          side;
   ams_step_if         st ();
   logic [15:0]        tick_cnt;
   logic               tick;
   logic [7:0]         wait_cnt;
   logic               start_req;
   logic [1:0]         ctrl_ant;
   logic               ctrl_hv;
   logic               st_done;
   logic               st_exh;
   logic               samp_r;
   logic               samp_g;
   logic               samp_x;
   logic [DET_W-1:0]   samp_fwd;
   logic [DET_W-1:0]   samp_refl;
   logic               mem_we;
   logic [ENTRY_W-1:0] saved;
   logic               bus_take;
   logic               tuning;

   assign bus_take = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
   assign tuning   = (state != S_IDLE);

   ams_step_eval u_eval (
      .s (st)
   );

   assign st.r_above            = samp_r;
   assign st.g_above            = samp_g;
   assign st.reactance_sign_bit = samp_x;
   assign st.fwd                = samp_fwd;
   assign st.refl               = samp_refl;
   assign st.coil               = series_coil_relays_o;
   assign st.cap                = shunt_cap_relays_o;
   assign st.side               = side;

   ams_store u_store (
      .clk_i   (clk_i),
      .we_i    (mem_we),
      .waddr_i (ctrl_ant),
      .wdata_i ({side, shunt_cap_relays_o, series_coil_relays_o}),
      .raddr_i (ctrl_ant),
      .rdata_o (saved)
   );

   // Millisecond enable; all tuning delays count these.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_cnt <= 16'h0000;
         tick     <= 1'b0;
      end else begin
         tick     <= (tick_cnt == 16'(TICK_LEN - 1));
         tick_cnt <= (tick_cnt == 16'(TICK_LEN - 1)) ? 16'h0000 : tick_cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= S_IDLE;
      end else begin
         case (state)
            S_IDLE:   if (start_req) state <= S_ARM;
            S_ARM:    state <= S_SETUP;
            S_SETUP:  state <= S_SETTLE;
            S_SETTLE: if (tick && wait_cnt == 8'(SETTLE_TICKS - 1)) state <= S_PULSE;
            S_PULSE:  if (tick && wait_cnt == 8'(PULSE_TICKS - 1)) state <= S_EVAL;
            S_EVAL: begin
               if (st.matched || st.exhausted) begin
                  state <= S_REPORT;
               end else begin
                  state <= S_SETTLE;
               end
            end
            // Routing relays drop first; the gate falls one cycle later, on the edge into idle.
            S_REPORT: if (!tx_active_i && !input_bypass_relay_o) state <= S_IDLE;
            default:  state <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_cnt <= 8'h00;
      end else if (state == S_SETUP || state == S_EVAL) begin
         wait_cnt <= 8'h00;
      end else if (tick) begin
         if ((state == S_SETTLE && wait_cnt == 8'(SETTLE_TICKS - 1)) ||
             (state == S_PULSE && wait_cnt == 8'(PULSE_TICKS - 1))) begin
            wait_cnt <= 8'h00;
         end else begin
            wait_cnt <= wait_cnt + 8'h01;
         end
      end
   end

   // The gate is up through every state of a cycle except the sensing pulse.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rf_block_gate_o       <= 1'b0;
         high_voltage_enable_o <= 1'b0;
      end else begin
         rf_block_gate_o <= (state == S_IDLE) ? start_req :
                            !(state == S_SETTLE && tick &&
                              wait_cnt == 8'(SETTLE_TICKS - 1)) &&
                            !(state == S_PULSE && !(tick &&
                              wait_cnt == 8'(PULSE_TICKS - 1))) &&
                            !(state == S_REPORT && !tx_active_i && !input_bypass_relay_o);
         high_voltage_enable_o <= ctrl_hv || start_req || tuning;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         samp_r    <= 1'b0;
         samp_g    <= 1'b0;
         samp_x    <= 1'b0;
         samp_fwd  <= '0;
         samp_refl <= '0;
      end else if (state == S_PULSE && tick && wait_cnt == 8'(PULSE_TICKS - 1)) begin
         samp_r    <= r_above_i;
         samp_g    <= g_above_i;
         samp_x    <= reactance_sign_bit_i;
         samp_fwd  <= fwd_level_i;
         samp_refl <= refl_level_i;
      end
   end

   // Relays move only in ARM..EVAL steps where the gate is already high.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         series_coil_relays_o    <= '0;
         shunt_cap_relays_o      <= '0;
         side                    <= SIDE_L;
         input_side_cap_relay_o  <= 1'b0;
         output_side_cap_relay_o <= 1'b0;
         antenna_select_relays_o <= ANT_RST;
      end else if (state == S_SETUP) begin
         series_coil_relays_o    <= '0;
         shunt_cap_relays_o      <= '0;
         side                    <= SIDE_L;
         input_side_cap_relay_o  <= 1'b1;
         output_side_cap_relay_o <= 1'b0;
         antenna_select_relays_o <= ANT_RST << ctrl_ant;
      end else if (state == S_EVAL && !st.matched && !st.exhausted) begin
         series_coil_relays_o    <= st.next_coil;
         shunt_cap_relays_o      <= st.next_cap;
         side                    <= st.next_side;
         input_side_cap_relay_o  <= (st.next_side == SIDE_L);
         output_side_cap_relay_o <= (st.next_side == SIDE_RL);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         input_bypass_relay_o <= 1'b0;
         sensor_route_relay_o <= 1'b0;
      end else if (state == S_SETUP) begin
         input_bypass_relay_o <= 1'b1;
         sensor_route_relay_o <= 1'b1;
      end else if (state == S_REPORT && !tx_active_i) begin
         input_bypass_relay_o <= 1'b0;
         sensor_route_relay_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_done        <= 1'b0;
         st_exh         <= 1'b0;
         tune_done_o    <= 1'b0;
         tune_matched_o <= 1'b0;
         mem_we         <= 1'b0;
      end else begin
         mem_we <= (state == S_EVAL) && st.matched;
         if (state == S_ARM) begin
            st_done        <= 1'b0;
            st_exh         <= 1'b0;
            tune_done_o    <= 1'b0;
            tune_matched_o <= 1'b0;
         end else if (state == S_EVAL && (st.matched || st.exhausted)) begin
            st_done        <= 1'b1;
            st_exh         <= !st.matched;
            tune_done_o    <= 1'b1;
            tune_matched_o <= st.matched;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         start_req <= 1'b0;
         ctrl_ant  <= CTRL_ANT_RST;
         ctrl_hv   <= CTRL_HV_RST;
      end else begin
         if (bus_take && avs_write_i && avs_address_i == REG_CTRL) begin
            ctrl_hv <= avs_writedata_i[CTRL_HV_BIT];
            if (!tuning) begin
               ctrl_ant <= avs_writedata_i[CTRL_ANT_LSB +: 2];
            end
         end
         // A start written while the first one waits is simply merged.
         if (bus_take && avs_write_i && avs_address_i == REG_CTRL &&
             avs_writedata_i[CTRL_START_BIT] && !tuning) begin
            start_req <= 1'b1;
         end else if (state == S_IDLE && start_req) begin
            start_req <= 1'b0;
         end
      end
   end

   // One wait cycle per access: the request is answered on the second edge.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end else begin
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
         if (avs_read_i && avs_waitrequest_o) begin
            case (avs_address_i)
               REG_CTRL:   avs_readdata_o <= {28'h0, ctrl_hv, ctrl_ant, start_req};
               REG_STATUS: avs_readdata_o <= {27'h0, state == S_REPORT, st_exh,
                                              tune_matched_o, st_done, tuning};
               REG_COIL:   avs_readdata_o <= {23'h0, series_coil_relays_o};
               REG_CAP:    avs_readdata_o <= {21'h0, side, shunt_cap_relays_o};
               REG_SAVED:  avs_readdata_o <= {12'h0, saved};
               default:    avs_readdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   sequence s_match_found;
      state == S_EVAL && st.matched;
   endsequence
   sequence s_pulse_end;
      state == S_PULSE ##1 state == S_EVAL;
   endsequence

   a_side_excl: assert property (@(posedge clk_i) disable iff (rst_i)
      !(input_side_cap_relay_o && output_side_cap_relay_o))
      else $error("both capacitor side relays on");
   a_relay_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
      ($changed(series_coil_relays_o) || $changed(shunt_cap_relays_o) ||
       $changed(antenna_select_relays_o) || $changed(input_bypass_relay_o))
      |-> rf_block_gate_o && $past(rf_block_gate_o))
      else $error("relay changed while RF passed");
   a_ant_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
      $onehot(antenna_select_relays_o))
      else $error("antenna select not one-hot");
   a_hv_on_tune: assert property (@(posedge clk_i) disable iff (rst_i)
      state == S_SETTLE |-> high_voltage_enable_o)
      else $error("high voltage off while tuning");
   a_idle_routes: assert property (@(posedge clk_i) disable iff (rst_i)
      state == S_IDLE && $past(state) == S_IDLE |-> !input_bypass_relay_o && !sensor_route_relay_o)
      else $error("routing relays energized in idle");
   a_tune_routes: assert property (@(posedge clk_i) disable iff (rst_i)
      state == S_PULSE |-> input_bypass_relay_o && sensor_route_relay_o)
      else $error("routing relays off during tuning");
   a_gate_settle: assert property (@(posedge clk_i) disable iff (rst_i)
      state == S_SETTLE ##1 state == S_SETTLE |-> rf_block_gate_o)
      else $error("gate low while settling");
   a_pulse_reblock: assert property (@(posedge clk_i) disable iff (rst_i)
      s_pulse_end |-> rf_block_gate_o && !$past(rf_block_gate_o))
      else $error("gate not reasserted after pulse");
   a_settle_first: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rf_block_gate_o) && tuning |-> $past(state) == S_SETTLE)
      else $error("pulse without settling");
   a_stop_match: assert property (@(posedge clk_i) disable iff (rst_i)
      s_match_found |=> state == S_REPORT && tune_done_o && tune_matched_o)
      else $error("match did not end tuning");
   a_release_tx: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(input_bypass_relay_o) |-> $past(state) == S_REPORT && !$past(tx_active_i))
      else $error("relays released before TX stop");
   a_save_match: assert property (@(posedge clk_i) disable iff (rst_i)
      s_match_found |=> mem_we)
      else $error("match not stored");
endmodule
`default_nettype wire

// >>> verification/ams_sensor_model.sv
// Bridge and detector model that answers each RF pulse of the sequencer.
// Assumes one clock; detectors read nothing while RF is blocked.
`timescale 1ns/1ps
`default_nettype none
module ams_sensor_model import ams_pkg::*; (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             gate_i,
   input  wire logic             bypass_i,
   input  wire logic [15:0]      match_after_i,
   output logic                  r_above_o,
   output logic                  g_above_o,
   output logic                  sign_o,
   output logic [DET_W-1:0]      fwd_o,
   output logic [DET_W-1:0]      refl_o,
   output logic [15:0]           pulses_o
);
   logic       gate_q;
   logic [2:0] flags;
   // Flags toggle while RF is blocked, so a stale sample never looks valid.
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         gate_q <= 1'b0;
         pulses_o <= 16'h0;
         flags <= 3'h0;
      end else begin
         gate_q <= gate_i;
         if (gate_q && !gate_i && bypass_i) begin
            pulses_o <= pulses_o + 16'h1;
            flags <= (match_after_i == 16'h0) ? 3'h0 : 3'($urandom);
         end else if (gate_i) begin
            flags <= ~flags;
         end
      end
   end
   assign {r_above_o, g_above_o, sign_o} = flags;
   assign fwd_o = gate_i ? 8'h00 : 8'hc8;
   assign refl_o = (gate_i || (match_after_i != 16'h0 && pulses_o >= match_after_i)) ?
                   8'h00 : 8'hc0;
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the tuning sequencer with a bridge model.
// Assumes the design package and a short tick for simulation.
`timescale 1ns/1ps
`default_nettype none
module tb_top import ams_pkg::*;;
   localparam int TL = 4;
   logic              clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic              r_above_i, g_above_i, reactance_sign_bit_i, tx_active_i;
   logic              input_side_cap_relay_o, output_side_cap_relay_o, high_voltage_enable_o;
   logic              input_bypass_relay_o, sensor_route_relay_o, rf_block_gate_o;
   logic              tune_done_o, tune_matched_o, pg, pb;
   logic [4:0]        avs_address_i;
   logic [31:0]       avs_writedata_i, avs_readdata_o, rd;
   logic [DET_W-1:0]  fwd_level_i, refl_level_i;
   logic [COIL_N-1:0] series_coil_relays_o;
   logic [CAP_N-1:0]  shunt_cap_relays_o;
   logic [ANT_N-1:0]  antenna_select_relays_o;
   logic [24:0]       prel;
   logic [15:0]       match_after, pulses;
   logic [1:0]        ant;
   int                miscompares, n_tests, lo_n, hi_n;

   always #12.5 clk_i = ~clk_i;

   ams_seq #(.TICK_LEN(TL)) DUT (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .r_above_i, .g_above_i,
      .reactance_sign_bit_i, .fwd_level_i, .refl_level_i, .tx_active_i,
      .series_coil_relays_o, .shunt_cap_relays_o, .input_side_cap_relay_o,
      .output_side_cap_relay_o, .antenna_select_relays_o, .high_voltage_enable_o,
      .input_bypass_relay_o, .sensor_route_relay_o, .rf_block_gate_o, .tune_done_o,
      .tune_matched_o);
   ams_sensor_model model (.clk_i, .rst_i, .gate_i(rf_block_gate_o),
      .bypass_i(input_bypass_relay_o), .match_after_i(match_after), .r_above_o(r_above_i),
      .g_above_o(g_above_i), .sign_o(reactance_sign_bit_i), .fwd_o(fwd_level_i),
      .refl_o(refl_level_i), .pulses_o(pulses));

   task automatic chk(input bit ok, input string m);
      n_tests++;
      if (!ok) begin
         miscompares++;
         $display("Error %0t: %s", $time, m);
      end
   endtask

   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (avs_waitrequest_o !== 1'b0 && k < 50);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      chk(k < 50, "bus timeout");
      @(posedge clk_i);
   endtask

   function automatic logic [ANT_N-1:0] exp_ant(input logic [1:0] a);
      return ANT_N'(1) << a;
   endfunction

   task automatic end_of_test;
      $display("Tests %0d, miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Relay moves are judged only in tuning mode; outside it RF bypasses the gate.
   always @(posedge clk_i) begin
      if (!rst_i && pb && input_bypass_relay_o) begin
         if (prel != {series_coil_relays_o, shunt_cap_relays_o, input_side_cap_relay_o,
                      output_side_cap_relay_o, antenna_select_relays_o} && !pg
             && !rf_block_gate_o) chk(1'b0, "relay moved with RF on");
         if (pg && !rf_block_gate_o) begin
            chk(hi_n >= (SETTLE_TICKS - 1) * TL, "settle too short");
            hi_n = 0;
         end
         if (!pg && rf_block_gate_o) begin
            chk(lo_n >= (PULSE_TICKS - 1) * TL && lo_n <= (PULSE_TICKS + 1) * TL, "pulse");
            lo_n = 0;
         end
         if (rf_block_gate_o) hi_n++;
         else lo_n++;
      end else begin
         hi_n = 0;
         lo_n = 0;
      end
      if (input_side_cap_relay_o === 1'b1 && output_side_cap_relay_o === 1'b1)
         chk(1'b0, "both side relays");
      if (!rst_i && input_bypass_relay_o !== sensor_route_relay_o)
         chk(1'b0, "bypass and sensor differ");
      prel = {series_coil_relays_o, shunt_cap_relays_o, input_side_cap_relay_o,
              output_side_cap_relay_o, antenna_select_relays_o};
      pg = rf_block_gate_o;
      pb = input_bypass_relay_o;
   end

   task automatic tune(input int run);
      int k;
      logic [15:0] p0;
      logic [ENTRY_W-1:0] e;
      p0 = pulses;
      match_after <= (run == 2) ? 16'h0 : (run == 1) ? 16'h1 : 16'(2 + $urandom % 6);
      ant = 2'($urandom);
      tx_active_i <= 1'b1;
      bus(REG_CTRL, 1'b1, {28'h0, 1'b0, ant, 1'b1});
      bus(REG_STATUS, 1'b0, 32'h0);
      chk(rd[ST_BUSY_BIT] === 1'b1 && rf_block_gate_o === 1'b1, "busy, gate");
      chk(high_voltage_enable_o === 1'b1 && antenna_select_relays_o === exp_ant(ant),
          "hv, antenna");
      k = 0;
      while (tune_done_o !== 1'b1 && k < 40000) begin
         @(posedge clk_i);
         k++;
      end
      chk(tune_matched_o === (run != 2) && k < 40000, "match result");
      if (run == 2) chk(series_coil_relays_o === COIL_MAX && shunt_cap_relays_o === '0
          && input_side_cap_relay_o === 1'b1, "exhausted range");
      if (run != 2) chk(pulses - p0 === match_after, "pulse count");
      bus(REG_STATUS, 1'b0, 32'h0);
      chk(rd[ST_EXH_BIT] === (run == 2) && rd[ST_WAIT_BIT] === 1'b1
          && input_bypass_relay_o === 1'b1, "report wait");
      bus(REG_COIL, 1'b0, 32'h0);
      chk(rd[COIL_N-1:0] === series_coil_relays_o, "coil");
      bus(REG_CAP, 1'b0, 32'h0);
      chk(rd[CAP_N-1:0] === shunt_cap_relays_o && input_side_cap_relay_o === !rd[CAP_N]
          && output_side_cap_relay_o === rd[CAP_N], "cap, side");
      e = {rd[CAP_N:0], series_coil_relays_o};
      if (run != 2) begin
         bus(REG_SAVED, 1'b0, 32'h0);
         chk(rd[ENTRY_W-1:0] === e, "saved entry");
      end
      tx_active_i <= 1'b0;
      k = 0;
      while (input_bypass_relay_o !== 1'b0 && k < 20) begin
         @(posedge clk_i);
         k++;
      end
      repeat (2) @(posedge clk_i);
      chk(k < 20 && sensor_route_relay_o === 1'b0 && rf_block_gate_o === 1'b0,
          "release");
   endtask

   initial begin
      ant = 2'($urandom(32'he477841e));
      {clk_i, rst_i, avs_read_i, avs_write_i, tx_active_i} = 5'h08;
      avs_address_i = 5'h00;
      avs_writedata_i = 32'h0;
      match_after = 16'h1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(antenna_select_relays_o === 4'h1 && high_voltage_enable_o === 1'b0, "reset");
      chk(input_bypass_relay_o === 1'b0 && sensor_route_relay_o === 1'b0, "idle");
      bus(5'h14, 1'b0, 32'h0);
      chk(rd === 32'h0, "unmapped read");
      for (int a = 0; a < 4; a++) begin
         bus(REG_CTRL, 1'b1, 32'((a << 1) | ((a & 1) << 3)));
         // The antenna relays may only move inside a tuning cycle, so they stay put here.
         bus(REG_CTRL, 1'b0, 32'h0);
         chk(rd[3:0] === 4'((a << 1) | ((a & 1) << 3)) && antenna_select_relays_o === 4'h1
             && high_voltage_enable_o === 1'((a & 1)), "antenna, hv");
      end
      for (int r = 0; r < 3; r++) tune(r);
      end_of_test;
   end

   initial begin
      repeat (60000) @(posedge clk_i);
      miscompares++;
      $display("Error %0t: watchdog", $time);
      end_of_test;
   end
endmodule
`default_nettype wire
